// ---- common/bcs_pkg.sv ----
package bcs_pkg;

    // Avalon byte offsets, one 32-bit word each
    localparam logic [5:0] BCS_OFS_CTRL = 6'h00;
    localparam logic [5:0] BCS_OFS_IAR = 6'h04;
    localparam logic [5:0] BCS_OFS_LAST = 6'h08;
    localparam logic [5:0] BCS_OFS_STATUS = 6'h0c;
    localparam logic [5:0] BCS_OFS_GPR0 = 6'h10;
    localparam logic [5:0] BCS_OFS_GPR7 = 6'h2c;

    // Control and status bit positions
    localparam int BCS_CTRL_GO = 0;
    localparam int BCS_CTRL_PROB = 1;
    localparam int BCS_ST_BUSY = 0;
    localparam int BCS_ST_DONE = 1;
    localparam int BCS_ST_INV = 2;
    localparam int BCS_ST_PROT = 3;
    localparam int BCS_ST_SPEC = 4;
    localparam int BCS_ST_ILL = 5;
    localparam int BCS_ST_CARRY = 8;
    localparam int BCS_ST_OVF = 9;
    localparam int BCS_ST_EVEN = 10;
    localparam int BCS_ST_NEG = 11;
    localparam int BCS_ST_ZERO = 12;

    // Values after reset
    localparam logic [15:0] BCS_RST_IAR = 16'h0000;
    localparam logic [15:0] BCS_RST_LAST = 16'hffff;

    // Instruction field positions, bit 0 is the most significant
    localparam int BCS_POS_OP = 0;
    localparam int BCS_POS_R1 = 5;
    localparam int BCS_POS_R2 = 8;
    localparam int BCS_POS_RB1 = 6;
    localparam int BCS_POS_RB = 8;
    localparam int BCS_POS_AM = 10;
    localparam int BCS_POS_AM2 = 12;
    localparam int BCS_POS_IND = 11;
    localparam int BCS_POS_DIR = 12;

    // Known encodings
    localparam logic [4:0] BCS_OP_SS = 5'h11;
    localparam logic [1:0] BCS_FN_SS_CLR = 2'h2;
    localparam logic [4:0] BCS_OP_RI = 5'h0f;
    localparam logic [4:0] BCS_FN_RI_CLR = 5'h04;
    localparam logic [7:0] BCS_OP_SI = 8'h40;
    localparam logic [3:0] BCS_FN_SI_CLR = 4'hd;
    localparam logic [3:0] BCS_FN_SI_SUB = 4'he;
    localparam logic [15:0] BCS_WORD_STEP = 16'h0002;

    typedef enum logic [6:0] {
        BCS_S_IDLE = 7'b000_0001,
        BCS_S_FETCH = 7'b000_0010,
        BCS_S_DECODE = 7'b000_0100,
        BCS_S_EA = 7'b000_1000,
        BCS_S_IND = 7'b001_0000,
        BCS_S_RD = 7'b010_0000,
        BCS_S_WR = 7'b100_0000
    } bcs_state_t;

    typedef enum logic [7:0] {
        BCS_K_BAD = 8'b0000_0001,
        BCS_K_RS = 8'b0000_0010,
        BCS_K_R1S = 8'b0000_0100,
        BCS_K_SS = 8'b0000_1000,
        BCS_K_RI_CLR = 8'b0001_0000,
        BCS_K_RI_SUB = 8'b0010_0000,
        BCS_K_SI_CLR = 8'b0100_0000,
        BCS_K_SI_SUB = 8'b1000_0000
    } bcs_kind_t;

    typedef struct packed {
        logic [5:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } bcs_avl_req_t;

    typedef struct packed {
        logic valid;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } bcs_mem_req_t;

    typedef struct packed {
        logic ack;
        logic [15:0] rdata;
        logic not_assigned;
        logic read_only;
    } bcs_mem_rsp_t;

endpackage : bcs_pkg

// ---- rtl/bcs_exec.sv ----
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Bit 12 selects register/storage clear direction
// - Storage ones clear register bits, storage kept
// - Register ones clear storage bits, register kept
// - Clears keep carry/overflow, update even/negative/zero
// - Address beyond installed storage terminates instruction
// - Problem state unassigned access or read-only destination terminates
// - Odd effective or indirect address terminates
// - R1/storage form clears first register bits
// - Address field plus second register, none if zero
// - Bit 11 selects direct or indirect address
// - Storage/storage clears operand 2 by operand 1
// - Register-immediate clear into second register
// - Storage-immediate clear of addressed word
// - Immediate word position follows address mode
// - Register-immediate subtract into second register
// - Storage-immediate subtract written back in place
// - Carry set on borrow out of MSB
// - Overflow set when difference leaves signed range
// - On overflow carry is complement of sign
// - Subtract updates even, negative, zero
module bcs_exec #(
    parameter logic [4:0] P_RS_OP = 5'h1a,
    parameter logic [2:0] P_RS_FN = 3'h5,
    parameter logic [4:0] P_R1S_OP = 5'h1b,
    parameter logic [3:0] P_R1S_FN = 4'h0,
    parameter logic [4:0] P_SA_RI_FN = 5'h06
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire bcs_pkg::bcs_avl_req_t avl_req,
    output logic [31:0] avl_readdata,
    output logic avl_waitrequest,
    output bcs_pkg::bcs_mem_req_t mem_req,
    input wire bcs_pkg::bcs_mem_rsp_t mem_rsp,
    output logic busy
);
    import bcs_pkg::*;

    typedef struct packed {
        bcs_state_t st;
        bcs_kind_t kind;
        logic [2:0][15:0] w;
        logic [1:0] wi;
        logic opn;
        logic [15:0] ea;
        logic [15:0] ind_add;
        logic [15:0] op1;
        logic [15:0] op2;
        logic [7:0][15:0] gpr;
        logic [15:0] iar;
        logic [15:0] last;
        logic prob;
        logic busy;
        logic done;
        logic [3:0] chk;
        logic [4:0] ind;
        logic rd_pend;
        logic [31:0] rdata;
        bcs_mem_req_t mreq;
    } bcs_regs_t;

    bcs_regs_t q, d;

    // Field pick with bit 0 as MSB
    function automatic logic [15:0] fld(input logic [15:0] w, input int pos, input int len);
        fld = (w >> (16 - pos - len)) & ((16'h0001 << len) - 16'h0001);
    endfunction : fld

    function automatic bcs_kind_t decode(input logic [15:0] w0);
        logic [4:0] op;
        op = 5'(fld(w0, BCS_POS_OP, 5));
        decode = BCS_K_BAD;
        if (op == P_RS_OP && 3'(fld(w0, 13, 3)) == P_RS_FN)
            decode = BCS_K_RS;
        else if (op == P_R1S_OP && 4'(fld(w0, 12, 4)) == P_R1S_FN)
            decode = BCS_K_R1S;
        else if (op == BCS_OP_SS && 2'(fld(w0, 14, 2)) == BCS_FN_SS_CLR && !w0[10])
            decode = BCS_K_SS;
        else if (op == BCS_OP_RI && 5'(fld(w0, 11, 5)) == BCS_FN_RI_CLR)
            decode = BCS_K_RI_CLR;
        else if (op == BCS_OP_RI && 5'(fld(w0, 11, 5)) == P_SA_RI_FN)
            decode = BCS_K_RI_SUB;
        // Bits 5-7 must be zero to match at all
        else if (w0[15:8] == BCS_OP_SI && w0[3:0] == BCS_FN_SI_CLR)
            decode = BCS_K_SI_CLR;
        else if (w0[15:8] == BCS_OP_SI && w0[3:0] == BCS_FN_SI_SUB)
            decode = BCS_K_SI_SUB;
    endfunction : decode

    // Instruction length in words
    function automatic logic [1:0] nwords(input bcs_kind_t k, input logic [15:0] w0);
        case (k)
            BCS_K_RS: nwords = w0[5] ? 2'd2 : 2'd1;
            BCS_K_R1S, BCS_K_RI_CLR, BCS_K_RI_SUB: nwords = 2'd2;
            BCS_K_SS: nwords = 2'd1 + {1'b0, w0[5]} + {1'b0, w0[3]};
            BCS_K_SI_CLR, BCS_K_SI_SUB: nwords = w0[5] ? 2'd3 : 2'd2;
            default: nwords = 2'd1;
        endcase
    endfunction : nwords

    // Even, negative, zero of a result
    function automatic logic [2:0] enz(input logic [15:0] r);
        enz = {r == 16'h0000, r[15], ~r[0]};
    endfunction : enz

    function automatic logic addr_bad(input logic [15:0] a, input logic [15:0] last);
        addr_bad = a > last;
    endfunction : addr_bad

    logic term, fin, wr_ok;
    logic [2:0] gidx;
    logic [1:0] rb;
    logic [1:0] am;
    logic [15:0] disp;
    logic [15:0] base;
    logic [15:0] imm;
    logic [15:0] res;
    logic [16:0] diff;
    logic [15:0] rdmux;
    logic [2:0] r1, r2;
    logic dst_mem;

    // Next state of the whole block
    always_comb
    begin
        d = q;
        term = 1'b0;
        fin = 1'b0;
        rb = 2'd0;
        am = 2'd0;
        disp = 16'h0000;
        base = 16'h0000;
        res = 16'h0000;
        diff = 17'h00000;
        r1 = 3'(fld(q.w[0], BCS_POS_R1, 3));
        r2 = 3'(fld(q.w[0], BCS_POS_R2, 3));
        // Immediate sits after the displacement word when AM is 10 or 11
        imm = ((q.kind == BCS_K_SI_CLR || q.kind == BCS_K_SI_SUB) && q.w[0][5]) ? q.w[2] : q.w[1];
        dst_mem = (q.kind == BCS_K_RS && q.w[0][3]) || q.kind == BCS_K_SI_CLR || q.kind == BCS_K_SI_SUB
            || (q.kind == BCS_K_SS && q.opn);

        // Register read mux, low half only
        rdmux = 16'h0000;
        gidx = 3'((avl_req.address - BCS_OFS_GPR0) >> 2);
        case (avl_req.address)
            BCS_OFS_CTRL: rdmux = {14'h0000, q.prob, 1'b0};
            BCS_OFS_IAR: rdmux = q.iar;
            BCS_OFS_LAST: rdmux = q.last;
            BCS_OFS_STATUS: rdmux = {3'h0, q.ind, 2'h0, q.chk, q.done, q.busy};
            default:
            begin
                if (avl_req.address >= BCS_OFS_GPR0 && avl_req.address <= BCS_OFS_GPR7 && avl_req.address[1:0] == 2'h0)
                    rdmux = q.gpr[gidx];
            end
        endcase

        // Reads answer one cycle after the request
        d.rd_pend = avl_req.read && !q.rd_pend;
        if (avl_req.read && !q.rd_pend)
            d.rdata = {16'h0000, rdmux};

        // Writes only land while idle; waitrequest holds them off otherwise
        wr_ok = avl_req.write && !q.busy;
        if (wr_ok)
        begin
            case (avl_req.address)
                BCS_OFS_CTRL:
                begin
                    d.prob = avl_req.writedata[BCS_CTRL_PROB];
                    if (avl_req.writedata[BCS_CTRL_GO])
                    begin
                        d.busy = 1'b1;
                        d.done = 1'b0;
                        d.chk = 4'h0;
                        d.wi = 2'd0;
                        d.opn = 1'b0;
                        d.st = BCS_S_FETCH;
                    end
                end
                BCS_OFS_IAR: d.iar = avl_req.writedata[15:0];
                BCS_OFS_LAST: d.last = avl_req.writedata[15:0];
                BCS_OFS_STATUS: d.ind = avl_req.writedata[BCS_ST_ZERO:BCS_ST_CARRY];
                default:
                begin
                    if (avl_req.address >= BCS_OFS_GPR0 && avl_req.address <= BCS_OFS_GPR7
                        && avl_req.address[1:0] == 2'h0)
                        d.gpr[gidx] = avl_req.writedata[15:0];
                end
            endcase
        end

        // Instruction sequencer
        case (q.st)
            BCS_S_IDLE: ;
            BCS_S_FETCH:
            begin
                if (!q.mreq.valid)
                begin
                    d.mreq.addr = q.iar + 16'({q.wi, 1'b0});
                    if (addr_bad(d.mreq.addr, q.last))
                        d.chk[0] = 1'b1;
                    else if (q.iar[0])
                        d.chk[2] = 1'b1;
                    else
                        d.mreq.valid = 1'b1;
                end
                else if (mem_rsp.ack)
                begin
                    d.mreq.valid = 1'b0;
                    d.w[q.wi] = mem_rsp.rdata;
                    if (q.prob && mem_rsp.not_assigned)
                        d.chk[1] = 1'b1;
                    else if (q.wi == 2'd0 && decode(mem_rsp.rdata) == BCS_K_BAD)
                        d.chk[3] = 1'b1;
                    else if (q.wi + 2'd1 < nwords(decode(d.w[0]), d.w[0]))
                        d.wi = q.wi + 2'd1;
                    else
                    begin
                        d.kind = decode(d.w[0]);
                        d.st = BCS_S_DECODE;
                    end
                end
            end
            BCS_S_DECODE:
            begin
                if (q.kind == BCS_K_RI_CLR)
                begin
                    res = q.gpr[r1] & ~q.w[1];
                    d.gpr[r2] = res;
                    d.ind[4:2] = enz(res);
                    fin = 1'b1;
                end
                else if (q.kind == BCS_K_RI_SUB)
                begin
                    diff = {1'b0, q.gpr[r1]} - {1'b0, q.w[1]};
                    d.gpr[r2] = diff[15:0];
                    d.ind[1] = (q.gpr[r1][15] != q.w[1][15]) && (diff[15] != q.gpr[r1][15]);
                    d.ind[0] = d.ind[1] ? ~diff[15] : diff[16];
                    d.ind[4:2] = enz(diff[15:0]);
                    fin = 1'b1;
                end
                else
                    d.st = BCS_S_EA;
            end
            BCS_S_EA:
            begin
                d.ind_add = 16'h0000;
                if (q.kind == BCS_K_R1S)
                begin
                    // Base of zero means no register; the base is never written
                    base = (r2 == 3'd0) ? 16'h0000 : q.gpr[r2];
                    d.ea = q.w[1] + base;
                    d.st = q.w[0][15 - BCS_POS_IND] ? BCS_S_IND : BCS_S_RD;
                end
                else
                begin
                    rb = 2'(fld(q.w[0], (q.kind == BCS_K_SS && !q.opn) ? BCS_POS_RB1 : BCS_POS_RB, 2));
                    am = 2'(fld(q.w[0], (q.kind == BCS_K_SS && q.opn) ? BCS_POS_AM2 : BCS_POS_AM, 2));
                    disp = (q.kind == BCS_K_SS && q.opn && q.w[0][5]) ? q.w[2] : q.w[1];
                    base = q.gpr[{1'b0, rb}];
                    case (am)
                        2'd0: d.ea = base;
                        2'd1:
                        begin
                            d.ea = base;
                            d.gpr[{1'b0, rb}] = base + BCS_WORD_STEP;
                        end
                        2'd2: d.ea = base + disp;
                        default:
                        begin
                            d.ea = base + {8'h00, disp[15:8]};
                            d.ind_add = {8'h00, disp[7:0]};
                        end
                    endcase
                    d.st = (am == 2'd3) ? BCS_S_IND : BCS_S_RD;
                end
            end
            BCS_S_IND, BCS_S_RD, BCS_S_WR:
            begin
                if (!q.mreq.valid)
                begin
                    if (addr_bad(q.ea, q.last))
                        d.chk[0] = 1'b1;
                    else if (q.ea[0])
                        d.chk[2] = 1'b1;
                    else
                    begin
                        d.mreq.valid = 1'b1;
                        d.mreq.we = (q.st == BCS_S_WR);
                        d.mreq.addr = q.ea;
                    end
                end
                else if (mem_rsp.ack)
                begin
                    d.mreq.valid = 1'b0;
                    // Read-only is seen on the read of a destination, before any write
                    if (q.prob && (mem_rsp.not_assigned
                        || (q.st == BCS_S_RD && dst_mem && mem_rsp.read_only)))
                        d.chk[1] = 1'b1;
                    else if (q.st == BCS_S_WR)
                        fin = 1'b1;
                    else if (q.st == BCS_S_IND)
                    begin
                        d.ea = mem_rsp.rdata + q.ind_add;
                        d.st = BCS_S_RD;
                    end
                    else if (q.kind == BCS_K_SS && !q.opn)
                    begin
                        d.op1 = mem_rsp.rdata;
                        d.opn = 1'b1;
                        d.st = BCS_S_EA;
                    end
                    else
                    begin
                        d.op2 = mem_rsp.rdata;
                        case (q.kind)
                            BCS_K_RS:
                            begin
                                if (q.w[0][15 - BCS_POS_DIR])
                                    res = mem_rsp.rdata & ~q.gpr[r1];
                                else
                                begin
                                    res = q.gpr[r1] & ~mem_rsp.rdata;
                                    d.gpr[r1] = res;
                                end
                            end
                            BCS_K_R1S:
                            begin
                                res = q.gpr[r1] & ~mem_rsp.rdata;
                                d.gpr[r1] = res;
                            end
                            BCS_K_SS: res = mem_rsp.rdata & ~q.op1;
                            BCS_K_SI_CLR: res = mem_rsp.rdata & ~imm;
                            BCS_K_SI_SUB:
                            begin
                                diff = {1'b0, mem_rsp.rdata} - {1'b0, imm};
                                res = diff[15:0];
                                d.ind[1] = (mem_rsp.rdata[15] != imm[15]) && (diff[15] != mem_rsp.rdata[15]);
                                d.ind[0] = d.ind[1] ? ~diff[15] : diff[16];
                            end
                            default: res = mem_rsp.rdata;
                        endcase
                        d.ind[4:2] = enz(res);
                        d.mreq.wdata = res;
                        if (dst_mem)
                            d.st = BCS_S_WR;
                        else
                            fin = 1'b1;
                    end
                end
            end
            default: term = 1'b1;
        endcase

        term = term || (|(d.chk & ~q.chk)); // A check raised now ends the instruction
        // Completion; a terminated instruction leaves the address register alone
        if (fin)
            d.iar = q.iar + 16'({nwords(q.kind, q.w[0]), 1'b0});
        if (fin || term)
        begin
            d.st = BCS_S_IDLE;
            d.busy = 1'b0;
            d.done = 1'b1;
            d.mreq.valid = 1'b0;
            d.mreq.we = 1'b0;
        end
    end

    // One register bank for all state
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            q <= '0;
            q.st <= BCS_S_IDLE;
            q.kind <= BCS_K_BAD;
            q.iar <= BCS_RST_IAR;
            q.last <= BCS_RST_LAST;
        end
        else
            q <= d;
    end

    // Handshake is combinational, data from flops
    assign avl_waitrequest = (avl_req.read && !q.rd_pend) || (avl_req.write && q.busy);
    assign avl_readdata = q.rdata;
    assign mem_req = q.mreq;
    assign busy = q.busy;

endmodule : bcs_exec

// ---- tb/bcs_mem_model.sv ----
`timescale 1ns/1ps
// Storage answering after lat idle cycles; rdata toggles between answers so stale data never match
module bcs_mem_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire bcs_pkg::bcs_mem_req_t mem_req,
    output bcs_pkg::bcs_mem_rsp_t mem_rsp,
    input wire logic [3:0] lat,
    input wire logic [15:0] prot_addr,
    input wire logic [1:0] prot_kind
);
    import bcs_pkg::*;
    logic [15:0] ram [0:32767];
    logic [3:0] cnt_q;
    logic hit;
    assign hit = mem_req.addr == prot_addr;
    // Writes land even in read-only areas, so a missed check shows up in memory
    always @(posedge clk)
    begin
        mem_rsp.ack <= 1'b0;
        mem_rsp.rdata <= ~mem_rsp.rdata;
        cnt_q <= 4'h0;
        if (!rst_b)
            mem_rsp <= '0;
        else if (mem_req.valid && !mem_rsp.ack)
        begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == lat)
            begin
                mem_rsp <= '{1'b1, ram[mem_req.addr[15:1]], hit && prot_kind[1], hit && prot_kind[0]};
                if (mem_req.we)
                    ram[mem_req.addr[15:1]] <= mem_req.wdata;
            end
        end
    end
endmodule : bcs_mem_model

// ---- tb/bcs_exec_asserts.sv ----
`timescale 1ns/1ps
module bcs_exec_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire bcs_pkg::bcs_avl_req_t avl_req,
    input wire logic [31:0] avl_readdata,
    input wire logic avl_waitrequest,
    input wire bcs_pkg::bcs_mem_req_t mem_req,
    input wire bcs_pkg::bcs_mem_rsp_t mem_rsp,
    input wire logic busy
);
    import bcs_pkg::*;
    logic [15:0] last_q, w0_q, rd_addr_q;
    logic prob_q, got_q, wr_seen_q, acc, wr;
    assign acc = avl_req.write && !avl_waitrequest;
    assign wr = mem_req.valid && mem_req.we;
    // Shadow limit and mode, first word and last read address of each instruction
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            last_q <= BCS_RST_LAST;
            prob_q <= 1'b0;
        end
        else if (acc && avl_req.address == BCS_OFS_LAST)
            last_q <= avl_req.writedata[15:0];
        else if (acc && avl_req.address == BCS_OFS_CTRL)
            prob_q <= avl_req.writedata[BCS_CTRL_PROB];
        got_q <= rst_b && busy && (got_q || mem_rsp.ack);
        wr_seen_q <= rst_b && busy && (wr_seen_q || (wr && mem_rsp.ack));
        if (mem_rsp.ack && !got_q)
            w0_q <= mem_rsp.rdata;
        if (mem_rsp.ack && !mem_req.we)
            rd_addr_q <= mem_req.addr;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_na;
        mem_rsp.ack && mem_rsp.not_assigned && prob_q;
    endsequence
    sequence s_ro;
        mem_rsp.ack && mem_rsp.read_only && !mem_req.we && prob_q;
    endsequence
    // Termination must follow soon
    sequence s_end;
        ##[0:15] !busy;
    endsequence
    AST_EVEN_ADDR: assert property (mem_req.valid |-> !mem_req.addr[0])
        else $error("odd address");
    AST_IN_RANGE: assert property (mem_req.valid |-> mem_req.addr <= last_q)
        else $error("address above limit");
    AST_NA_STOP: assert property (s_na |=> !mem_req.valid throughout s_end)
        else $error("access after protect");
    AST_RO_KEEP: assert property (s_ro |=> !(wr && mem_req.addr == rd_addr_q) throughout s_end)
        else $error("read-only written");
    AST_WB_SAME: assert property (wr && got_q && w0_q[15:8] == BCS_OP_SI |-> mem_req.addr == rd_addr_q)
        else $error("write not in place");
    AST_NO_STORE: assert property (got_q && w0_q[15:11] == BCS_OP_RI |-> !wr)
        else $error("immediate form wrote storage");
    AST_DIR_LOAD: assert property (got_q && w0_q[15:11] == 5'h1a && !w0_q[3] |-> !wr)
        else $error("load direction wrote storage");
    AST_ONE_WRITE: assert property (wr |-> !wr_seen_q)
        else $error("second write");
endmodule : bcs_exec_asserts

bind bcs_exec bcs_exec_asserts u_asserts (.clk(clk), .rst_b(rst_b), .avl_req(avl_req),
    .avl_readdata(avl_readdata), .avl_waitrequest(avl_waitrequest), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .busy(busy));

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import bcs_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    bcs_avl_req_t avl = '0;
    logic [31:0] rdata, q;
    logic avl_wait, busy;
    bcs_mem_req_t mreq;
    bcs_mem_rsp_t mrsp;
    logic [3:0] lat = 4'h0;
    logic [15:0] paddr = 16'h0;
    logic [1:0] pkind = 2'h0;
    logic [15:0] prog[$];
    logic [17:0] e;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    always #2.5 clk = ~clk;
    bcs_exec uut (.clk(clk), .rst_b(rst_b), .avl_req(avl), .avl_readdata(rdata),
        .avl_waitrequest(avl_wait), .mem_req(mreq), .mem_rsp(mrsp), .busy(busy));
    bcs_mem_model mem (.clk(clk), .rst_b(rst_b), .mem_req(mreq), .mem_rsp(mrsp), .lat(lat),
        .prot_addr(paddr), .prot_kind(pkind));
    // Hang guard far above the few hundred cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            results();
        end
    end
    task automatic results();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
        avl <= '{a, !w, w, {16'h0, d}};
        do
            @(posedge clk);
        while (avl_wait !== 1'b0);
        q = rdata;
        avl <= '0;
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rc(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 16'h0);
        chk(q, exp);
    endtask : rc
    task automatic mc(input logic [15:0] a, input logic [15:0] exp);
        chk({16'h0, mem.ram[a[15:1]]}, {16'h0, exp});
    endtask : mc
    function automatic logic [5:0] g(input int n);
        return BCS_OFS_GPR0 + 6'(4 * n);
    endfunction : g
    // Done plus zero, negative, even, overflow, carry
    function automatic logic [31:0] st(input logic [15:0] r, input logic c, input logic v);
        return {19'h0, r == 16'h0, r[15], !r[0], v, c, 8'h02};
    endfunction : st
    function automatic logic [17:0] sub(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] d;
        logic v;
        d = {1'b0, a} - {1'b0, b};
        v = (a[15] != b[15]) && (d[15] != a[15]);
        return {v ? !d[15] : d[16], v, d[15:0]};
    endfunction : sub
    // Program sits at 0100; q holds the status afterwards
    task automatic go(input logic p);
        foreach (prog[i])
            mem.ram[16'h80 + i] = prog[i];
        wr(BCS_OFS_IAR, 16'h0100);
        wr(BCS_OFS_CTRL, {14'h0, p, 1'b1});
        while (busy !== 1'b0)
            @(posedge clk);
        bus(1'b0, BCS_OFS_STATUS, 16'h0);
    endtask : go
    task automatic t_sub();
        wr(g(1), 16'h8000);
        prog = '{{BCS_OP_RI, 3'd1, 3'd2, 5'h06}, 16'h0001};
        go(1'b0);
        e = sub(16'h8000, 16'h0001);
        chk(q, st(e[15:0], e[17], e[16]));
        rc(g(2), {16'h0, e[15:0]});
        rc(g(1), 32'h8000);
        wr(g(3), 16'h0200);
        mem.ram[16'h100] = 16'h0001;
        prog = '{{BCS_OP_SI, 2'd3, 2'b00, BCS_FN_SI_SUB}, 16'h0002};
        go(1'b0);
        e = sub(16'h0001, 16'h0002);
        chk(q, st(e[15:0], e[17], e[16]));
        mc(16'h0200, e[15:0]);
        $display("t_sub done");
    endtask : t_sub
    task automatic t_clr();
        wr(BCS_OFS_STATUS, 16'h0300);
        wr(g(1), 16'hffff);
        prog = '{{BCS_OP_RI, 3'd1, 3'd4, BCS_FN_RI_CLR}, 16'h00ff};
        go(1'b0);
        chk(q, st(16'hff00, 1'b1, 1'b1));
        rc(g(4), 32'hff00);
        rc(g(1), 32'hffff);
        lat <= 4'h3;
        mem.ram[16'h108] = 16'h0f0f;
        prog = '{{BCS_OP_SI, 2'd3, 2'b10, BCS_FN_SI_CLR}, 16'h0010, 16'h0303};
        go(1'b0);
        chk(q, st(16'h0c0c, 1'b1, 1'b1));
        mc(16'h0210, 16'h0c0c);
        lat <= 4'h0;
        $display("t_clr done");
    endtask : t_clr
    task automatic t_rs();
        wr(BCS_OFS_STATUS, 16'h0);
        wr(g(5), 16'hffff);
        mem.ram[16'h100] = 16'hf0f0;
        prog = '{{5'h1a, 3'd5, 2'd3, 2'b00, 1'b0, 3'h5}};
        go(1'b0);
        chk(q, st(16'h0f0f, 1'b0, 1'b0));
        rc(g(5), 32'h0f0f);
        wr(g(5), 16'h00ff);
        prog = '{{5'h1a, 3'd5, 2'd3, 2'b00, 1'b1, 3'h5}};
        go(1'b0);
        mc(16'h0200, 16'hf000);
        rc(g(5), 32'h00ff);
        wr(g(0), 16'h0040);
        wr(g(6), 16'hffff);
        mem.ram[16'h110] = 16'h0230;
        mem.ram[16'h118] = 16'h8001;
        prog = '{{5'h1b, 3'd6, 3'd0, 1'b1, 4'h0}, 16'h0220};
        go(1'b0);
        rc(g(6), 32'h7ffe);
        mc(16'h0230, 16'h8001);
        wr(g(2), 16'h0240);
        mem.ram[16'h120] = 16'hffff;
        prog = '{{BCS_OP_SS, 1'b0, 2'd3, 2'd2, 2'b00, 2'b00, BCS_FN_SS_CLR}};
        go(1'b0);
        mc(16'h0240, 16'h0fff);
        mc(16'h0200, 16'hf000);
        $display("t_rs done");
    endtask : t_rs
    task automatic t_chk();
        rc(6'h30, 32'h0);
        rc(BCS_OFS_LAST, 32'hffff);
        wr(BCS_OFS_LAST, 16'h01ff);
        prog = '{{BCS_OP_SI, 2'd3, 2'b00, BCS_FN_SI_CLR}, 16'hffff};
        go(1'b0);
        chk(q & 32'h3f, 32'h06);
        wr(BCS_OFS_LAST, 16'hffff);
        wr(g(3), 16'h0201);
        go(1'b0);
        chk(q & 32'h3f, 32'h12);
        wr(g(3), 16'h0200);
        paddr <= 16'h0200;
        pkind <= 2'b01;
        go(1'b1);
        chk(q & 32'h3f, 32'h0a);
        mc(16'h0200, 16'hf000);
        paddr <= 16'h0100;
        pkind <= 2'b10;
        go(1'b1);
        chk(q & 32'h3f, 32'h0a);
        pkind <= 2'b00;
        $display("t_chk done");
    endtask : t_chk
    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_sub();
        t_clr();
        t_rs();
        t_chk();
        results();
    end
endmodule : testbench
